// ---- core/epd_pkg.sv ----
// Functional notes
// - prescaler register reads bit 7 as zero, low seven bits live, resets to 7f
// - counter register read/write any time, shows live count, resets to ff
// - underflow flag sets when counter goes from 00 to ff
// - timer irq raised while irq enable and underflow flag are both one
// - init bit low holds prescaler at 7f and stops counter
// - tap select divides prescaler input by two to the field value
// - status/control resets to all zero
// - prescaler ticks at core rate over 12, decrements, reloads 7f after zero
// - counter decrements per tap pulse while enabled, reloads ff after zero
// - flag also set by writing 00 to counter or one to status bit 7
// - counter write beats a simultaneous decrement; no flag from that decrement
package epd_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_PRESCALER = 8'hd2;
  localparam logic [7:0] ADDR_COUNTER   = 8'hd3;
  localparam logic [7:0] ADDR_STATUS    = 8'hd4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0] PRESCALER_RST  = 7'h7f;
  localparam logic [7:0] COUNTER_RST    = 8'hff;
  localparam logic [7:0] STATUS_RST     = 8'h00;

  // ****************************************************************
  // status/control field positions
  // ****************************************************************
  localparam int BIT_UNDERFLOW = 7;
  localparam int BIT_IRQ_EN    = 6;
  localparam int BIT_RES_SET   = 5;
  localparam int BIT_RES_CLR   = 4;
  localparam int BIT_INIT_RUN  = 3;
  localparam int TAP_LSB       = 0;
  localparam int TAP_W         = 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          INT_DIV     = 12;
  localparam logic [3:0]  DIV_LAST    = 4'h0b;

endpackage

// ---- core/epd_timer.sv ----
`timescale 1ns/1ps
module epd_timer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timer_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  div_r;
    logic [6:0]  presc_r;
    logic [7:0]  count_r;
    logic [7:0]  stat_r;
    logic [31:0] dat_r;
    logic        ack_r;
    logic        irq_r;
  } epd_state_s;

  epd_state_s st_r;
  epd_state_s st_nxt;

  logic        req;
  logic        wr;
  logic        rd;
  logic        lane0;
  logic        tick;
  logic        tap_pulse;
  logic [6:0]  presc_dec;
  logic [7:0]  rd_byte;
  logic [7:0]  wstat;
  logic        cnt_wr;
  logic        flag_set;

  // tap pulse: prescaler bit n-1 falls on this tick, giving divide by 2^n
  function automatic logic tap_fall(input logic [6:0] cur,
                                    input logic [6:0] nxt,
                                    input logic [2:0] sel);
    logic r;
    r = 1'b0;
    if (sel == 3'h0) begin
      r = 1'b1;
    end else begin
      r = cur[sel - 3'h1] & ~nxt[sel - 3'h1];
    end
    return r;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt    = st_r;
    req       = wb_cyc_i & wb_stb_i & ~st_r.ack_r;
    wr        = req & wb_we_i;
    rd        = req & ~wb_we_i;
    lane0     = wb_sel_i[0];
    tick      = st_r.div_r == epd_pkg::DIV_LAST;
    presc_dec = st_r.presc_r - 7'h01;
    tap_pulse = 1'b0;
    wstat     = wb_dat_i[7:0];

    // core rate over 12 feeds the prescaler
    st_nxt.div_r = tick ? 4'h0 : st_r.div_r + 4'h1;

    if (!st_r.stat_r[epd_pkg::BIT_INIT_RUN]) begin
      st_nxt.presc_r = epd_pkg::PRESCALER_RST;
    end else if (tick) begin
      // the wrap 00->7f only raises bits, so no tap falls on it
      if (st_r.presc_r == 7'h00) begin
        st_nxt.presc_r = epd_pkg::PRESCALER_RST;
      end else begin
        st_nxt.presc_r = presc_dec;
        tap_pulse = tap_fall(st_r.presc_r, presc_dec,
                   st_r.stat_r[epd_pkg::TAP_LSB +: epd_pkg::TAP_W]);
      end
      if (st_r.stat_r[epd_pkg::TAP_LSB +: epd_pkg::TAP_W] == 3'h0) begin
        tap_pulse = 1'b1;
      end
    end

    // counter: decrement on tap pulse; a counter write suppresses its wrap
    cnt_wr   = wr && lane0 && wb_adr_i == epd_pkg::ADDR_COUNTER;
    flag_set = 1'b0;
    if (tap_pulse) begin
      st_nxt.count_r = st_r.count_r - 8'h01;
      flag_set = (st_r.count_r == 8'h00) && !cnt_wr;
    end

    // direct prescaler write allowed only while running
    if (wr && lane0 && wb_adr_i == epd_pkg::ADDR_PRESCALER &&
        st_r.stat_r[epd_pkg::BIT_INIT_RUN]) begin
      st_nxt.presc_r = wb_dat_i[6:0];
    end

    // a counter write wins over the decrement
    if (cnt_wr) begin
      st_nxt.count_r = wb_dat_i[7:0];
      flag_set = flag_set | (wb_dat_i[7:0] == 8'h00);
    end

    // status write may clear the flag; a set in the same cycle wins
    if (wr && lane0 && wb_adr_i == epd_pkg::ADDR_STATUS) begin
      st_nxt.stat_r = wstat;
    end
    if (flag_set) begin
      st_nxt.stat_r[epd_pkg::BIT_UNDERFLOW] = 1'b1;
    end

    // read mux, unmapped reads zero
    case (wb_adr_i)
      epd_pkg::ADDR_PRESCALER: rd_byte = {1'b0, st_r.presc_r};
      epd_pkg::ADDR_COUNTER:   rd_byte = st_r.count_r;
      epd_pkg::ADDR_STATUS:    rd_byte = st_r.stat_r;
      default:                 rd_byte = 8'h00;
    endcase
    st_nxt.dat_r = rd ? {24'h000000, rd_byte} : 32'h00000000;
    st_nxt.ack_r = req;

    st_nxt.irq_r = st_nxt.stat_r[epd_pkg::BIT_IRQ_EN] &
                   st_nxt.stat_r[epd_pkg::BIT_UNDERFLOW];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // async reset as the house style asks; every field loads a constant
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r.div_r   <= 4'h0;
      st_r.presc_r <= epd_pkg::PRESCALER_RST;
      st_r.count_r <= epd_pkg::COUNTER_RST;
      st_r.stat_r  <= epd_pkg::STATUS_RST;
      st_r.dat_r   <= 32'h00000000;
      st_r.ack_r   <= 1'b0;
      st_r.irq_r   <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o  = st_r.dat_r;
  assign wb_ack_o  = st_r.ack_r;
  assign timer_irq = st_r.irq_r;

endmodule // epd_timer

// ---- verif/epd_timer_checker.sv ----
`timescale 1ns/1ps
module epd_timer_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_irq
);
  // ****************************************
  // bus answer and interrupt relations
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // reads are judged at the ack edge, where the master still holds adr/we
  property p_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o;
  endproperty
  a_take: assert property (p_take) else $error("no ack after request");
  property p_pulse;
    wb_ack_o && clk_en |=> !wb_ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_quiet;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data off ack");
  property p_psc;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hd2 |-> wb_dat_o[31:7] == 25'h0;
  endproperty
  a_psc: assert property (p_psc) else $error("prescaler top bit");
  property p_unmap;
    wb_ack_o && !wb_we_i && !(wb_adr_i inside {[8'hd2:8'hd4]})
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_irq_on;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hd4 && wb_dat_o[7:6] == 2'b11
      |=> timer_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hd4 && !wb_dat_o[6] |=> !timer_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
  c_irq: cover property ($rose(timer_irq));
  c_rd: cover property (wb_ack_o && !wb_we_i);
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule // epd_timer_checker

// ---- verif/epd_timer_tb_top.sv ----
`timescale 1ns/1ps
module epd_timer_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 32'h9a69;
  int          wt;
  int          lo;
  logic        ce = 1'b1;
  logic [7:0]  v;
  always #50 clk = ~clk;
  // status writes always keep bit 5 set and bit 4 clear
  epd_timer u_dut (.core_clk(clk), .rst(rst), .clk_en(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .timer_irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle; upper sel lanes random, lane 0 always on
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    sel <= 4'($random(seed)) | 4'h1;
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // read data monitor plus hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      close_out();
    end
    if (ack === 1'b1 && we === 1'b0)
      check(dat_o, {24'h0, exp_q.pop_front()});
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'hd2, 8'h7f);
    rd(8'hd3, 8'hff);
    rd(8'hd4, 8'h00);
    bus(1'b1, 8'hd7, 8'h5a);
    rd(8'hd7, 8'h00);
    v = 8'($random(seed));
    bus(1'b1, 8'hd2, v);
    rd(8'hd2, 8'h7f);
    bus(1'b1, 8'hd3, v);
    repeat (50) @(posedge clk);
    rd(8'hd3, v);
    bus(1'b1, 8'hd3, 8'h00);
    rd(8'hd4, 8'h80);
    bus(1'b1, 8'hd4, 8'ha0);
    rd(8'hd4, 8'ha0);
    check(32'(irq), 32'h0);
    bus(1'b1, 8'hd4, 8'he0);
    rd(8'hd4, 8'he0);
    check(32'(irq), 32'h1);
    bus(1'b1, 8'hd4, 8'h20);
    rd(8'hd4, 8'h20);
    check(32'(irq), 32'h0);
    // freeze: divide by one with clk_en low; status is rewritten before the read, so no wrap is checked
    bus(1'b1, 8'hd3, 8'h03);
    bus(1'b1, 8'hd4, 8'h28);
    ce <= 1'b0;
    repeat (1000) @(posedge clk);
    ce <= 1'b1;
    bus(1'b1, 8'hd4, 8'h20);
    rd(8'hd4, 8'h20);
    // two tap pulses from 01 to the wrap; window allows tick phase slack
    for (int n = 0; n < 8; n++) begin
      bus(1'b1, 8'hd3, 8'h01);
      bus(1'b1, 8'hd4, 8'h68 | 8'(n));
      wt = 0;
      while (irq !== 1'b1 && wt < 4000) begin
        @(posedge clk);
        wt++;
      end
      lo = 12 * ((n == 0) ? 1 : (3 << (n - 1)) - 1);
      check(32'(wt > lo && wt <= lo + 12), 32'h1);
      rd(8'hd4, 8'he8 | 8'(n));
      bus(1'b1, 8'hd4, 8'h20);
      rd(8'hd3, 8'hff);
    end
    close_out();
  end
endmodule // epd_timer_tb_top
bind epd_timer epd_timer_checker u_chk (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timer_irq(timer_irq));
